// file: csal_cfg.svh
// csal_cfg.svh: offsets, field positions, reset values and timing figures
// of the charger status and alert block.
// assumes: included by bare name; clock runs at 250 MHz.
`ifndef CSAL_CFG_SVH
`define CSAL_CFG_SVH

// register sub-addresses
`define CSAL_ADDR_PHASE_FLAGS    8'h34
`define CSAL_ADDR_LOOP_FLAGS     8'h35
`define CSAL_ADDR_LIMIT_ALERTS   8'h36
`define CSAL_ADDR_PHASE_ALERTS   8'h37

// register widths
`define CSAL_PHASE_W             11
`define CSAL_LOOP_W              4
`define CSAL_LIMIT_W             16

// phase flag positions (shared by the phase entry alerts)
`define CSAL_BIT_EQUALIZE        10
`define CSAL_BIT_ABSORB          9
`define CSAL_BIT_SUSPENDED       8
`define CSAL_BIT_PRECONDITION    7
`define CSAL_BIT_BULK_REG        6
`define CSAL_BIT_THERM_PAUSE     5
`define CSAL_BIT_TIMER_TERM      4
`define CSAL_BIT_CX_TERM         3
`define CSAL_BIT_CHG_TIME_FAULT  2
`define CSAL_BIT_BAT_MISSING     1
`define CSAL_BIT_BAT_SHORT       0

// control loop flag positions
`define CSAL_BIT_LOOP_UVCL       3
`define CSAL_BIT_LOOP_IIN        2
`define CSAL_BIT_LOOP_ICHG       1
`define CSAL_BIT_LOOP_VBAT       0

// limit alert positions; bit 14 is reserved and reads zero
`define CSAL_BIT_MEAS_VALID      15
`define CSAL_LIMIT_USED_MASK     16'hBFFF

// reset values
`define CSAL_RST_PHASE           11'h000
`define CSAL_RST_LOOP            4'h0
`define CSAL_RST_LIMIT           16'h0000
`define CSAL_RST_RDATA           16'h0000

// timing
`define CSAL_CLK_KHZ             250000
`define CSAL_MEAS_CYCLE_MS       6.5
`define CSAL_WARMUP_MS           12.0

`endif

// file: csal_pkg.sv
// csal_pkg.sv: types of the charger status and alert block.
// assumes: nothing beyond the compiler.
package csal_pkg;

  // battery chemistry as strapped by the charger core
  typedef enum logic [1:0] {
    CSAL_CHEM_LI_ION    = 2'b00,
    CSAL_CHEM_LIFEPO4   = 2'b01,
    CSAL_CHEM_LEAD_ACID = 2'b10,
    CSAL_CHEM_RSVD      = 2'b11
  } csal_chem_t;

  // charger phase reported by the charger algorithm
  typedef enum logic [3:0] {
    CSAL_PH_IDLE        = 4'b0000,
    CSAL_PH_BAT_SHORT   = 4'b0001,
    CSAL_PH_BAT_MISSING = 4'b0010,
    CSAL_PH_TIME_FAULT  = 4'b0011,
    CSAL_PH_CX_TERM     = 4'b0100,
    CSAL_PH_TIMER_TERM  = 4'b0101,
    CSAL_PH_THERM_PAUSE = 4'b0110,
    CSAL_PH_BULK_REG    = 4'b0111,
    CSAL_PH_PRECOND     = 4'b1000,
    CSAL_PH_SUSPENDED   = 4'b1001,
    CSAL_PH_ABSORB      = 4'b1010,
    CSAL_PH_EQUALIZE    = 4'b1011
  } csal_phase_t;

  // regulation loop in control of charge current
  typedef enum logic [2:0] {
    CSAL_LOOP_NONE = 3'b000,
    CSAL_LOOP_VBAT = 3'b001,
    CSAL_LOOP_ICHG = 3'b010,
    CSAL_LOOP_IIN  = 3'b011,
    CSAL_LOOP_UVCL = 3'b100
  } csal_loop_t;

endpackage

// file: csal_sticky_bank.sv
// csal_sticky_bank.sv: a bank of sticky alert bits with enable gating,
// write-zero clear and re-trigger of a cleared bit whose cause persists.
// assumes: all inputs come from logic on the same clock.
`timescale 1ns/1ps
module csal_sticky_bank #(
  parameter int W = 16
) (
  // clock and reset
  input  wire logic         clock,
  input  wire logic         arst_n,
  // causes and controls
  input  wire logic [W-1:0] enable,
  input  wire logic [W-1:0] event_set,
  input  wire logic [W-1:0] cause_hold,
  input  wire logic [W-1:0] clear_mask,
  // state
  output logic      [W-1:0] flags_ff,
  output logic              new_alert
);

  logic [W-1:0] nxt_flags;
  logic [W-1:0] set_now;

  // a clear of a bit whose cause still holds counts as a fresh set
  always_comb begin
    set_now   = enable & (event_set | (clear_mask & cause_hold));
    nxt_flags = ((flags_ff & ~clear_mask) | set_now) & enable;
  end

  // sticky bits; set beats clear, removing the enable drops the bit
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      flags_ff <= '0;
    end else begin
      flags_ff <= nxt_flags;
    end
  end

  // only a bit not yet standing, or one re-raised over a clear, is new;
  // a cause that persists across cycle ends must not re-pull the line
  assign new_alert = |(set_now & (~flags_ff | clear_mask));

endmodule

// file: csal_top.sv
// csal_top.sv: charger phase and control loop status, limit excursion and
// phase entry alerts, and the open-drain alert line.
// assumes: the serial port front end decodes sub-address accesses on this
// clock and reports a finished alert response as a one-cycle pulse.
`timescale 1ns/1ps
`include "csal_cfg.svh"

module csal_top #(
  parameter int MEAS_CYCLES   = int'(`CSAL_MEAS_CYCLE_MS * `CSAL_CLK_KHZ),
  parameter int WARMUP_CYCLES = int'(`CSAL_WARMUP_MS * `CSAL_CLK_KHZ)
) (
  // clock and reset
  input  wire logic                      clock,
  input  wire logic                      arst_n,
  // charger core state
  input  wire csal_pkg::csal_chem_t      chem,
  input  wire csal_pkg::csal_phase_t     charger_phase,
  input  wire csal_pkg::csal_loop_t      control_loop,
  // measurement comparators, one per limit alert position
  input  wire logic [`CSAL_LIMIT_W-1:0]  limit_excursion,
  // alert enables held elsewhere
  input  wire logic [`CSAL_LIMIT_W-1:0]  limit_alert_enable,
  input  wire logic [`CSAL_PHASE_W-1:0]  phase_alert_enable,
  // sub-address access from the serial port
  input  wire logic [7:0]                reg_addr,
  input  wire logic                      reg_wr,
  input  wire logic                      reg_rd,
  input  wire logic [15:0]               reg_wdata,
  output logic      [15:0]               reg_rdata_ff,
  output logic                           reg_rvalid_ff,
  // alert response completed by the serial port
  input  wire logic                      ara_done,
  // open-drain alert line
  output logic                           smbalert_o,
  output logic                           smbalert_oe,
  // measurement timing, for the core
  output logic                           meas_cycle_end,
  output logic                           meas_valid_ff
);

  localparam int MEAS_CNT_W = $clog2(MEAS_CYCLES + 1);
  localparam int WARM_CNT_W = $clog2(WARMUP_CYCLES + 1);
  localparam logic [MEAS_CNT_W-1:0] MEAS_LAST = MEAS_CNT_W'(MEAS_CYCLES - 1);
  localparam logic [WARM_CNT_W-1:0] WARM_LAST = WARM_CNT_W'(WARMUP_CYCLES - 1);

  logic                     lithium;
  logic                     lead_acid;
  logic [`CSAL_PHASE_W-1:0] nxt_phase;
  logic [`CSAL_PHASE_W-1:0] phase_flags_ff;
  logic [`CSAL_PHASE_W-1:0] phase_prev_ff;
  logic [`CSAL_LOOP_W-1:0]  nxt_loop;
  logic [`CSAL_LOOP_W-1:0]  loop_flags_ff;
  logic [MEAS_CNT_W-1:0]    meas_cnt_ff;
  logic [WARM_CNT_W-1:0]    warm_cnt_ff;
  logic                     meas_tick;
  logic [`CSAL_LIMIT_W-1:0] excursion_held_ff;
  logic [`CSAL_LIMIT_W-1:0] limit_event;
  logic [`CSAL_LIMIT_W-1:0] limit_hold;
  logic [`CSAL_LIMIT_W-1:0] limit_clear;
  logic [`CSAL_LIMIT_W-1:0] limit_alerts;
  logic [`CSAL_PHASE_W-1:0] phase_entry;
  logic [`CSAL_PHASE_W-1:0] phase_clear;
  logic [`CSAL_PHASE_W-1:0] phase_alerts;
  logic                     limit_new;
  logic                     phase_new;
  logic                     warm_done;
  logic                     alert_low_ff;
  logic [15:0]              nxt_rdata;

  // chemistry decode; a reserved code counts as neither family
  assign lithium   = (chem == csal_pkg::CSAL_CHEM_LI_ION) ||
                     (chem == csal_pkg::CSAL_CHEM_LIFEPO4);
  assign lead_acid = (chem == csal_pkg::CSAL_CHEM_LEAD_ACID);

  // phase code to one-hot flags; one code means one bit at most
  always_comb begin
    nxt_phase = `CSAL_RST_PHASE;
    unique case (charger_phase)
      csal_pkg::CSAL_PH_IDLE:        nxt_phase = `CSAL_RST_PHASE;
      csal_pkg::CSAL_PH_BAT_SHORT:   nxt_phase[`CSAL_BIT_BAT_SHORT] = 1'b1;
      csal_pkg::CSAL_PH_BAT_MISSING: nxt_phase[`CSAL_BIT_BAT_MISSING] = 1'b1;
      csal_pkg::CSAL_PH_TIME_FAULT:  nxt_phase[`CSAL_BIT_CHG_TIME_FAULT] = lithium;
      csal_pkg::CSAL_PH_CX_TERM:     nxt_phase[`CSAL_BIT_CX_TERM] = lithium;
      csal_pkg::CSAL_PH_TIMER_TERM:  nxt_phase[`CSAL_BIT_TIMER_TERM] = lithium;
      csal_pkg::CSAL_PH_THERM_PAUSE: nxt_phase[`CSAL_BIT_THERM_PAUSE] = lithium;
      csal_pkg::CSAL_PH_BULK_REG:    nxt_phase[`CSAL_BIT_BULK_REG] = 1'b1;
      csal_pkg::CSAL_PH_PRECOND:
        nxt_phase[`CSAL_BIT_PRECONDITION] = (chem == csal_pkg::CSAL_CHEM_LI_ION);
      csal_pkg::CSAL_PH_SUSPENDED:   nxt_phase[`CSAL_BIT_SUSPENDED] = 1'b1;
      csal_pkg::CSAL_PH_ABSORB:
        nxt_phase[`CSAL_BIT_ABSORB] = (chem == csal_pkg::CSAL_CHEM_LIFEPO4) || lead_acid;
      csal_pkg::CSAL_PH_EQUALIZE:    nxt_phase[`CSAL_BIT_EQUALIZE] = lead_acid;
      default:                       nxt_phase = `CSAL_RST_PHASE;
    endcase
  end

  // loop code to one-hot flags
  always_comb begin
    nxt_loop = `CSAL_RST_LOOP;
    unique case (control_loop)
      csal_pkg::CSAL_LOOP_NONE: nxt_loop = `CSAL_RST_LOOP;
      csal_pkg::CSAL_LOOP_VBAT: nxt_loop[`CSAL_BIT_LOOP_VBAT] = 1'b1;
      csal_pkg::CSAL_LOOP_ICHG: nxt_loop[`CSAL_BIT_LOOP_ICHG] = 1'b1;
      csal_pkg::CSAL_LOOP_IIN:  nxt_loop[`CSAL_BIT_LOOP_IIN] = 1'b1;
      csal_pkg::CSAL_LOOP_UVCL: nxt_loop[`CSAL_BIT_LOOP_UVCL] = 1'b1;
      default:                  nxt_loop = `CSAL_RST_LOOP;
    endcase
  end

  // status flags and the previous phase for entry detection
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      phase_flags_ff <= `CSAL_RST_PHASE;
      phase_prev_ff  <= `CSAL_RST_PHASE;
      loop_flags_ff  <= `CSAL_RST_LOOP;
    end else begin
      phase_flags_ff <= nxt_phase;
      phase_prev_ff  <= phase_flags_ff;
      loop_flags_ff  <= nxt_loop;
    end
  end

  // measurement cycle divider, one-cycle enable at each cycle end
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      meas_cnt_ff <= '0;
    end else if (meas_tick) begin
      meas_cnt_ff <= '0;
    end else begin
      meas_cnt_ff <= meas_cnt_ff + 1'b1;
    end
  end
  assign meas_tick      = (meas_cnt_ff == MEAS_LAST);
  assign meas_cycle_end = meas_tick;

  // warm-up timer; stops once results are valid
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      warm_cnt_ff   <= '0;
      meas_valid_ff <= 1'b0;
    end else if (!meas_valid_ff) begin
      warm_cnt_ff   <= warm_cnt_ff + 1'b1;
      meas_valid_ff <= warm_done;
    end
  end
  assign warm_done = (warm_cnt_ff == WARM_LAST);

  // excursions are only looked at once per measurement cycle, so a
  // glitch between two cycle ends never reaches software
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      excursion_held_ff <= `CSAL_RST_LIMIT;
    end else if (meas_tick) begin
      excursion_held_ff <= limit_excursion & `CSAL_LIMIT_USED_MASK;
    end
  end

  // limit causes: comparator bits at cycle end, warm-up done for bit 15
  always_comb begin
    limit_event = meas_tick ? (limit_excursion & `CSAL_LIMIT_USED_MASK) : '0;
    limit_event[`CSAL_BIT_MEAS_VALID] = warm_done && !meas_valid_ff;
    limit_hold  = excursion_held_ff;
    limit_hold[`CSAL_BIT_MEAS_VALID] = meas_valid_ff;
  end

  // write-zero clears; other addresses and one bits clear nothing
  always_comb begin
    limit_clear = '0;
    phase_clear = '0;
    if (reg_wr && (reg_addr == `CSAL_ADDR_LIMIT_ALERTS)) begin
      limit_clear = ~reg_wdata;
    end
    if (reg_wr && (reg_addr == `CSAL_ADDR_PHASE_ALERTS)) begin
      phase_clear = ~reg_wdata[`CSAL_PHASE_W-1:0];
    end
  end

  // entry into a state is a flag rising, not the flag standing
  assign phase_entry = phase_flags_ff & ~phase_prev_ff;

  // limit excursion alerts
  csal_sticky_bank #(
    .W(`CSAL_LIMIT_W)
  ) u_limit_bank (
    .clock      (clock),
    .arst_n     (arst_n),
    .enable     (limit_alert_enable & `CSAL_LIMIT_USED_MASK),
    .event_set  (limit_event),
    .cause_hold (limit_hold),
    .clear_mask (limit_clear),
    .flags_ff   (limit_alerts),
    .new_alert  (limit_new)
  );

  // phase entry alerts, same positions as the phase flags
  csal_sticky_bank #(
    .W(`CSAL_PHASE_W)
  ) u_phase_bank (
    .clock      (clock),
    .arst_n     (arst_n),
    .enable     (phase_alert_enable),
    .event_set  (phase_entry),
    .cause_hold (phase_flags_ff),
    .clear_mask (phase_clear),
    .flags_ff   (phase_alerts),
    .new_alert  (phase_new)
  );

  // alert line held low from any new alert until the response completes;
  // a new alert in the response cycle keeps it low
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      alert_low_ff <= 1'b0;
    end else if (limit_new || phase_new) begin
      alert_low_ff <= 1'b1;
    end else if (ara_done) begin
      alert_low_ff <= 1'b0;
    end
  end
  assign smbalert_o  = 1'b0;          // open drain: only ever pulls low
  assign smbalert_oe = alert_low_ff;

  // read mux; unmapped sub-addresses read zero
  always_comb begin
    nxt_rdata = `CSAL_RST_RDATA;
    unique case (reg_addr)
      `CSAL_ADDR_PHASE_FLAGS:  nxt_rdata = {5'h00, phase_flags_ff};
      `CSAL_ADDR_LOOP_FLAGS:   nxt_rdata = {12'h000, loop_flags_ff};
      `CSAL_ADDR_LIMIT_ALERTS: nxt_rdata = limit_alerts;
      `CSAL_ADDR_PHASE_ALERTS: nxt_rdata = {5'h00, phase_alerts};
      default:                 nxt_rdata = `CSAL_RST_RDATA;
    endcase
  end

  // read data registered, valid one cycle after the strobe
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata_ff  <= `CSAL_RST_RDATA;
      reg_rvalid_ff <= 1'b0;
    end else begin
      reg_rvalid_ff <= reg_rd;
      if (reg_rd) begin
        reg_rdata_ff <= nxt_rdata;
      end
    end
  end

endmodule

// file: csal_host_model.sv
// csal_host_model.sv: host side of the alert line, answers an asserted line
// with a completed alert response after a short or a long delay.
// assumes: alert_line is the resolved open-drain level, pulled up when idle.
`timescale 1ns/1ps
module csal_host_model (
  // clock and reset
  input  wire logic clock,
  input  wire logic arst_n,
  // test controls
  input  wire logic hold,
  input  wire logic slow,
  // alert line and response
  input  wire logic alert_line,
  output logic      ara_done
);
  int cnt;
  // response pulse after the line has been low for the chosen delay
  always @(negedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cnt = 0;
      ara_done <= 1'b0;
    end else begin
      ara_done <= 1'b0;
      if (alert_line || hold) begin
        cnt = 0;
      end else if (cnt >= (slow ? 12 : 1)) begin
        ara_done <= 1'b1;
        cnt = 0;
      end else begin
        cnt++;
      end
    end
  end
endmodule

// file: csal_top_checker.sv
// csal_top_checker.sv: concurrent checks on the ports of the status block.
// assumes: bound into csal_top; one clock domain.
`timescale 1ns/1ps
module csal_top_checker #(
  parameter int MEAS_CYCLES   = 20,
  parameter int WARMUP_CYCLES = 50
) (
  // clock and reset
  input wire logic                  clock,
  input wire logic                  arst_n,
  // watched ports
  input wire csal_pkg::csal_chem_t  chem,
  input wire csal_pkg::csal_phase_t charger_phase,
  input wire csal_pkg::csal_loop_t  control_loop,
  input wire logic [10:0]           phase_alert_enable,
  input wire logic [7:0]            reg_addr,
  input wire logic                  reg_rd,
  input wire logic [15:0]           reg_rdata_ff,
  input wire logic                  reg_rvalid_ff,
  input wire logic                  ara_done,
  input wire logic                  smbalert_o,
  input wire logic                  smbalert_oe,
  input wire logic                  meas_cycle_end,
  input wire logic                  meas_valid_ff
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  int gap_ff;
  int up_ff;
  logic seen_ff;
  logic [3:0] lexp;
  // expected loop flag for a code, codes outside 1..4 mean none
  assign lexp = (control_loop inside {[1:4]}) ? 4'h1 << (control_loop - 3'h1) : 4'h0;
  // cycles since last cycle end and since reset release
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      gap_ff <= 0;
      up_ff <= 0;
      seen_ff <= 1'b0;
    end else begin
      gap_ff <= meas_cycle_end ? 0 : gap_ff + 1;
      up_ff <= up_ff + 1;
      seen_ff <= seen_ff | meas_cycle_end;
    end
  end
  sequence s_enter;
    $changed(charger_phase) && charger_phase == csal_pkg::CSAL_PH_PRECOND &&
      chem == csal_pkg::CSAL_CHEM_LI_ION && phase_alert_enable[7];
  endsequence
  sequence s_settle;
    ($stable(charger_phase) && $stable(chem) && phase_alert_enable[7]) [*2];
  endsequence
  property p_entry;
    s_enter ##1 s_settle |-> ##[1:3] smbalert_oe;
  endproperty
  property p_loop_map;
    reg_rd && reg_addr == 8'h35 && $past(control_loop) == control_loop
      |=> reg_rdata_ff == {12'h000, $past(lexp)};
  endproperty
  property p_loop_hot;
    reg_rvalid_ff && $past(reg_addr) == 8'h35 |-> $onehot0(reg_rdata_ff[3:0]) &&
      reg_rdata_ff[15:4] == 12'h000;
  endproperty
  property p_phase_hot;
    reg_rvalid_ff && $past(reg_addr) == 8'h34 |-> $onehot0(reg_rdata_ff);
  endproperty
  property p_alert_hold;
    smbalert_oe && !ara_done |=> smbalert_oe;
  endproperty
  property p_od;
    smbalert_oe |-> smbalert_o == 1'b0;
  endproperty
  property p_meas_period;
    meas_cycle_end |-> !seen_ff || gap_ff == MEAS_CYCLES - 1;
  endproperty
  property p_meas_gap;
    gap_ff <= MEAS_CYCLES;
  endproperty
  property p_warm_time;
    $rose(meas_valid_ff) |-> up_ff >= WARMUP_CYCLES - 2 && up_ff <= WARMUP_CYCLES + 1;
  endproperty
  property p_warm_keep;
    meas_valid_ff |=> meas_valid_ff;
  endproperty
  a_entry: assert property (p_entry) else $error("no alert on phase entry");
  a_loop_map: assert property (p_loop_map) else $error("loop flag wrong");
  a_loop_hot: assert property (p_loop_hot) else $error("loop flags not exclusive");
  a_phase_hot: assert property (p_phase_hot) else $error("phase flags not exclusive");
  a_alert_hold: assert property (p_alert_hold) else $error("alert line let go");
  a_od: assert property (p_od) else $error("alert line driven high");
  a_meas_period: assert property (p_meas_period) else $error("cycle end spacing");
  a_meas_gap: assert property (p_meas_gap) else $error("cycle end missing");
  a_warm_time: assert property (p_warm_time) else $error("warm-up length");
  a_warm_keep: assert property (p_warm_keep) else $error("valid dropped");
endmodule

bind csal_top csal_top_checker #(.MEAS_CYCLES(MEAS_CYCLES), .WARMUP_CYCLES(WARMUP_CYCLES))
  csal_top_checker_inst (.clock, .arst_n, .chem, .charger_phase, .control_loop,
  .phase_alert_enable, .reg_addr, .reg_rd, .reg_rdata_ff, .reg_rvalid_ff, .ara_done,
  .smbalert_o, .smbalert_oe, .meas_cycle_end, .meas_valid_ff);

// file: csal_top_test.sv
// csal_top_test.sv: self-checking bench of the status and alert block.
// assumes: short measurement counts; host model answers the alert line.
`timescale 1ns/1ps
module csal_top_test;
  logic                  clock              = 1'b0;
  logic                  arst_n             = 1'b0;
  csal_pkg::csal_chem_t  chem               = csal_pkg::CSAL_CHEM_LI_ION;
  csal_pkg::csal_phase_t charger_phase      = csal_pkg::CSAL_PH_IDLE;
  csal_pkg::csal_loop_t  control_loop       = csal_pkg::CSAL_LOOP_NONE;
  logic [15:0]           limit_excursion    = 16'h0000;
  logic [15:0]           limit_alert_enable = 16'h8000;
  logic [10:0]           phase_alert_enable = 11'h7FF;
  logic [7:0]            reg_addr           = 8'h00;
  logic                  reg_wr             = 1'b0;
  logic                  reg_rd             = 1'b0;
  logic [15:0]           reg_wdata          = 16'h0000;
  logic                  hold               = 1'b0;
  logic                  slow               = 1'b0;
  logic [15:0]           reg_rdata_ff;
  logic                  reg_rvalid_ff, ara_done, smbalert_o, smbalert_oe;
  logic                  meas_cycle_end, meas_valid_ff;
  int                    error_cnt          = 0;
  int                    tests_run          = 0;
  // resolved open-drain level, pulled up when released
  wire logic alert_line = smbalert_oe ? smbalert_o : 1'b1;
  csal_top #(.MEAS_CYCLES(20), .WARMUP_CYCLES(50)) csal_top_inst (.clock, .arst_n,
    .chem, .charger_phase, .control_loop, .limit_excursion, .limit_alert_enable,
    .phase_alert_enable, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata_ff,
    .reg_rvalid_ff, .ara_done, .smbalert_o, .smbalert_oe, .meas_cycle_end, .meas_valid_ff);
  csal_host_model csal_host_model_inst (.clock, .arst_n, .hold, .slow, .alert_line, .ara_done);
  always #2 clock = ~clock;
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    @(negedge clock);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clock);
    reg_rd = 1'b0;
    chk({15'h0000, reg_rvalid_ff}, 16'h0001);
    chk(reg_rdata_ff, exp);
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge clock);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clock);
    reg_wr = 1'b0;
  endtask
  // step just past the next measurement cycle end
  task automatic wait_meas;
    int n;
    n = 0;
    while (meas_cycle_end !== 1'b1 && n < 40) begin
      @(negedge clock);
      n++;
    end
    chk({15'h0000, meas_cycle_end}, 16'h0001);
    @(negedge clock);
  endtask
  // flag one edge later, entry alert one more
  task automatic phase_to(input csal_pkg::csal_chem_t c, input csal_pkg::csal_phase_t p);
    @(negedge clock);
    chem = c;
    charger_phase = p;
    repeat (3) @(negedge clock);
  endtask
  task automatic t_reset;
    rd(8'h34, 16'h0000);
    rd(8'h37, 16'h0000);
    wr(8'h34, 16'hFFFF);
    rd(8'h34, 16'h0000);
    rd(8'h50, 16'h0000);
  endtask
  task automatic t_loops;
    for (int i = 0; i < 5; i++) begin
      @(negedge clock);
      control_loop = csal_pkg::csal_loop_t'(i);
      repeat (2) @(negedge clock);
      rd(8'h35, (i == 0) ? 16'h0000 : 16'h0001 << (i - 1));
    end
  endtask
  task automatic t_phases;
    logic [15:0] acc;
    acc = 16'h0000;
    for (int i = 1; i < 12; i++) begin
      phase_to((i > 8) ? csal_pkg::CSAL_CHEM_LEAD_ACID : csal_pkg::CSAL_CHEM_LI_ION,
               csal_pkg::csal_phase_t'(i));
      acc = acc | (16'h0001 << (i - 1));
      rd(8'h34, 16'h0001 << (i - 1));
      rd(8'h37, acc);
    end
    phase_to(csal_pkg::CSAL_CHEM_LEAD_ACID, csal_pkg::CSAL_PH_PRECOND);
    rd(8'h34, 16'h0000);
    phase_to(csal_pkg::CSAL_CHEM_LEAD_ACID, csal_pkg::CSAL_PH_CX_TERM);
    rd(8'h34, 16'h0000);
  endtask
  task automatic t_sticky;
    phase_to(csal_pkg::CSAL_CHEM_LI_ION, csal_pkg::CSAL_PH_BAT_SHORT);
    wr(8'h37, 16'h07FE);
    rd(8'h37, 16'h07FF);
    wr(8'h37, 16'h07FD);
    rd(8'h37, 16'h07FD);
    phase_to(csal_pkg::CSAL_CHEM_LI_ION, csal_pkg::CSAL_PH_BAT_MISSING);
    rd(8'h37, 16'h07FF);
    phase_alert_enable[1] = 1'b0;
    rd(8'h37, 16'h07FD);
    phase_alert_enable[1] = 1'b1;
    rd(8'h37, 16'h07FD);
    phase_to(csal_pkg::CSAL_CHEM_LI_ION, csal_pkg::CSAL_PH_IDLE);
    wr(8'h37, 16'h0000);
    rd(8'h37, 16'h0000);
  endtask
  task automatic t_limits;
    limit_alert_enable = 16'hFFFE;
    rd(8'h36, 16'h8000);
    chk({15'h0000, meas_valid_ff}, 16'h0001);
    wait_meas();
    limit_excursion = 16'h7FFF;
    rd(8'h36, 16'h8000);
    wait_meas();
    rd(8'h36, 16'hBFFE);
    limit_excursion = 16'h0000;
    wait_meas();
    wr(8'h36, 16'hFFEF);
    rd(8'h36, 16'hBFEE);
    wr(8'h36, 16'h0000);
    rd(8'h36, 16'h8000);
  endtask
  task automatic t_ara;
    int n;
    // non-blocking: the host model samples these on the same falling edge
    hold <= 1'b1;
    slow <= 1'b1;
    phase_to(csal_pkg::CSAL_CHEM_LI_ION, csal_pkg::CSAL_PH_BAT_SHORT);
    repeat (20) @(negedge clock);
    chk({15'h0000, smbalert_oe}, 16'h0001);
    hold <= 1'b0;
    n = 0;
    while (smbalert_oe !== 1'b0 && n < 30) begin
      @(negedge clock);
      n++;
    end
    chk({15'h0000, smbalert_oe}, 16'h0000);
  endtask
  task automatic finish_test;
    $display("checks=%0d errors=%0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // watchdog well beyond the expected run length
  initial begin
    #80000;
    error_cnt++;
    finish_test();
  end
  initial begin
    repeat (12) @(negedge clock);
    arst_n = 1'b1;
    t_reset();
    t_loops();
    t_phases();
    t_sticky();
    t_limits();
    t_ara();
    finish_test();
  end
endmodule
